// ==== hdl/debug_break_defs.svh ====
// Purpose: constants for the debug exception and bus break unit
// Assumes: 32-bit APB, word-aligned registers
// Notes:   offsets are byte addresses
// Notes on behaviour
// - bus match raises a debug break or trace trigger per control setting.
// - a data mask bit of 1 drops that data bit from the compare.
// - compare only on access classes enabled in bus break control.
// - with trace enabled a match drives code 010 or 001 on status output.
// - debug exception outranks every exception except reset.
// - causes are single step, breakpoint instruction, hardware match, probe break request.
// - no debug exception of any cause is taken in debug mode.
// - hardware match breaks only when its break enable bit is set.
// - vector is FF200200 with probe present, else BFC00480; both uncached.
// - entry sets debug mode and touches only status and return address.
// - cause bits record step, breakpoint, load match and other match sources.
// - instruction address cause beats breakpoint; probe request is lowest.
// - breakpoint in delay slot saves branch address and sets delay flag.
// - other causes save the faulting address; step saves the next one.
// - no single step exception for a delay slot instruction.
// - no step at return target, nor its delay slot if it is a branch.
// - debug mode takes only reset exceptions and masks all interrupts.
// - interrupt arriving in debug mode is held and taken after leaving.
// - translation fault in debug mode: access dropped, only fault bit set.
// - bus error in debug mode: no exception, fault bit set, result dropped.
// - debug mode grants kernel privilege regardless of user mode bit.
// - trace outputs indirect jump targets, exception return counted; code traces only is_indirect retires, not returns.
// - debug return loads pc from return address, clears mode and break.
`ifndef DEBUG_BREAK_DEFS_SVH
`define DEBUG_BREAK_DEFS_SVH
`define OFS_BUS_STATUS    8'h00
`define OFS_BUS_ADDRESS   8'h04
`define OFS_BUS_DATA      8'h08
`define OFS_BUS_DATA_MASK 8'h0C
`define OFS_BUS_CONTROL   8'h10
`define OFS_BUS_ADDR_MASK 8'h14
`define OFS_DEBUG_STATUS  8'h18
`define OFS_RETURN_ADDR   8'h1C
`define OFS_SCRATCH       8'h20
`define VEC_PROBE         32'hFF200200
`define VEC_NO_PROBE      32'hBFC00480
`define PCST_STALL_TRIG   3'h2
`define PCST_SEQ_TRIG     3'h1
`define PCST_IDLE         3'h0
`define CTL_FETCH_UC      0
`define CTL_LOAD_UC       1
`define CTL_STORE_UC      2
`define CTL_CACHED        3
`define CTL_TRACE         4
`define CTL_BREAK         5
`define DBG_STEP_CAUSE    0
`define DBG_BP_CAUSE      1
`define DBG_LOAD_CAUSE    2
`define DBG_IADDR_CAUSE   4
`define DBG_BUS_CAUSE     5
`define DBG_PROBE_CAUSE   6
`define DBG_STEP_EN       8
`define DBG_TLF           11
`define DBG_BSF           12
`define DBG_MODE          30
`define DBG_DELAY_SLOT    31
`endif

// ==== hdl/debug_break_pkg.sv ====
// Purpose: shared types of the debug exception and bus break unit
// Assumes: fixed 32-bit address and data
// Notes:   state of the unit is one packed struct
package debug_break_pkg;
    typedef enum logic [2:0] {
        CLASS_NONE,
        CLASS_FETCH_UC,
        CLASS_LOAD_UC,
        CLASS_STORE_UC,
        CLASS_LOAD_C,
        CLASS_STORE_C
    } access_class_t;

    typedef struct packed {
        logic          valid;
        access_class_t kind;
        logic [31:0]   addr;
        logic [31:0]   data;
    } cpu_bus_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] next_pc;
        logic [31:0] branch_pc;
        logic        in_delay_slot;
        logic        is_branch;
        logic        is_breakpoint;
        logic        is_return;
        logic        is_indirect;
        logic [31:0] jump_target;
        logic        addr_match;
        logic        load_match;
        logic        stalled;
    } retire_t;

    typedef struct packed {
        logic        bus_hit;
        logic [31:0] bus_addr;
        logic [31:0] bus_data;
        logic [31:0] bus_mask;
        logic [31:0] bus_amask;
        logic [5:0]  bus_ctl;
        logic [31:0] dbg_status;
        logic [31:0] ret_addr;
        logic [31:0] scratch;
        logic        break_pend;
        logic        probe_pend;
        logic        nmi_pend;
        logic        break_status;
        logic [1:0]  skip_step;
        logic [31:0] prdata;
        logic        pslverr;
        logic        redirect;
        logic [31:0] redirect_pc;
        logic        debug_entry;
        logic        nmi_take;
        logic        exc_take;
        logic        drop_access;
        logic [2:0]  pcst;
        logic        trace_valid;
        logic [31:0] trace_target;
    } state_t;
endpackage : debug_break_pkg

// ==== hdl/debug_exception_bus_break.sv ====
// Purpose: bus break compare, debug exception entry and debug mode policy
// Assumes: pipeline presents one retiring instruction a cycle with its flags
// Notes:   APB answers with no wait states; read data comes from flops
//
// The register offsets and the APB interface to the registers were left to the implementer.
`include "debug_break_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module debug_exception_bus_break (
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    // apb slave
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic                           pready_o,
    output logic [31:0]                    prdata_o,
    output logic                           pslverr_o,
    // cpu side
    input  wire debug_break_pkg::cpu_bus_t cpu_bus_i,
    input  wire debug_break_pkg::retire_t  retire_i,
    input  wire logic                      probe_present_i,
    input  wire logic                      probe_break_i,
    input  wire logic                      nmi_i,
    input  wire logic                      irq_i,
    input  wire logic                      exception_i,
    input  wire logic                      translation_fault_i,
    input  wire logic                      bus_error_i,
    input  wire logic                      user_mode_i,
    output logic                           debug_mode_o,
    output logic                           debug_entry_o,
    output logic                           redirect_o,
    output logic [31:0]                    redirect_pc_o,
    output logic                           nmi_take_o,
    output logic                           exception_take_o,
    output logic                           irq_mask_o,
    output logic                           drop_access_o,
    output logic                           kernel_priv_o,
    output logic                           break_status_o,
    output logic [2:0]                     pcst_o,
    output logic                           trace_valid_o,
    output logic [31:0]                    trace_target_o
);

    debug_break_pkg::state_t state;
    debug_break_pkg::state_t next_state;

    logic        in_debug;
    logic        class_on;
    logic        bus_match;
    logic        step_hit;
    logic        bp_hit;
    logic        iaddr_hit;
    logic        load_hit;
    logic        bus_hit;
    logic        probe_hit;
    logic        any_cause;
    logic        setup;
    logic        access;
    logic        mapped;
    logic [31:0] read_word;

    assign in_debug = state.dbg_status[`DBG_MODE];

    // ------------------------------------------------------------------
    // bus match compare
    // ------------------------------------------------------------------
    always_comb begin
        case (cpu_bus_i.kind)
            debug_break_pkg::CLASS_FETCH_UC:
                class_on = state.bus_ctl[`CTL_FETCH_UC];
            debug_break_pkg::CLASS_LOAD_UC:
                class_on = state.bus_ctl[`CTL_LOAD_UC];
            debug_break_pkg::CLASS_STORE_UC:
                class_on = state.bus_ctl[`CTL_STORE_UC];
            debug_break_pkg::CLASS_LOAD_C,
            debug_break_pkg::CLASS_STORE_C:
                class_on = state.bus_ctl[`CTL_CACHED];
            default:
                class_on = 1'b0;
        endcase
    end

    // masked address and data must both agree in the same bus cycle
    assign bus_match = cpu_bus_i.valid && class_on
        && (((cpu_bus_i.addr ^ state.bus_addr) & ~state.bus_amask) == '0)
        && (((cpu_bus_i.data ^ state.bus_data) & ~state.bus_mask) == '0);

    // ------------------------------------------------------------------
    // debug exception causes
    // ------------------------------------------------------------------
    assign iaddr_hit = retire_i.valid && retire_i.addr_match;
    assign bp_hit    = retire_i.valid && retire_i.is_breakpoint;
    assign load_hit  = retire_i.valid && retire_i.load_match;
    assign bus_hit   = retire_i.valid && state.break_pend;
    assign probe_hit = retire_i.valid
        && (state.probe_pend || probe_break_i);
    // delay slots and return targets never single step
    assign step_hit  = retire_i.valid && state.dbg_status[`DBG_STEP_EN]
        && !retire_i.in_delay_slot
        && (state.skip_step == 2'h0);
    // nothing is taken while already in debug mode
    assign any_cause = !in_debug
        && (iaddr_hit || bp_hit || load_hit || bus_hit || probe_hit
            || step_hit);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i;

    always_comb begin
        mapped    = 1'b1;
        read_word = 32'h00000000;
        case (paddr_i)
            `OFS_BUS_STATUS:    read_word = {31'h0, state.bus_hit};
            `OFS_BUS_ADDRESS:   read_word = state.bus_addr;
            `OFS_BUS_DATA:      read_word = state.bus_data;
            `OFS_BUS_DATA_MASK: read_word = state.bus_mask;
            `OFS_BUS_CONTROL:   read_word = {26'h0, state.bus_ctl};
            `OFS_BUS_ADDR_MASK: read_word = state.bus_amask;
            `OFS_DEBUG_STATUS:  read_word = state.dbg_status;
            `OFS_RETURN_ADDR:   read_word = state.ret_addr;
            `OFS_SCRATCH:       read_word = state.scratch;
            default:            mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state             = state;
        next_state.redirect    = 1'b0;
        next_state.debug_entry = 1'b0;
        next_state.nmi_take    = 1'b0;
        next_state.exc_take    = 1'b0;
        next_state.drop_access = 1'b0;
        next_state.trace_valid = 1'b0;
        next_state.pcst        = `PCST_IDLE;

        // read data captured in setup, answered in access
        if (setup) begin
            next_state.prdata  = mapped ? read_word : 32'h00000000;
            next_state.pslverr = !mapped;
        end

        // software writes
        if (access && pwrite_i) begin
            case (paddr_i)
                `OFS_BUS_STATUS:
                    if (pwdata_i[0]) begin
                        next_state.bus_hit = 1'b0;
                    end
                `OFS_BUS_ADDRESS:   next_state.bus_addr  = pwdata_i;
                `OFS_BUS_DATA:      next_state.bus_data  = pwdata_i;
                `OFS_BUS_DATA_MASK: next_state.bus_mask  = pwdata_i;
                `OFS_BUS_CONTROL:   next_state.bus_ctl   = pwdata_i[5:0];
                `OFS_BUS_ADDR_MASK: next_state.bus_amask = pwdata_i;
                `OFS_DEBUG_STATUS:
                    next_state.dbg_status[`DBG_STEP_EN] =
                        pwdata_i[`DBG_STEP_EN];
                `OFS_RETURN_ADDR:   next_state.ret_addr  = pwdata_i;
                `OFS_SCRATCH:       next_state.scratch   = pwdata_i;
                default:            next_state.scratch   = state.scratch;
            endcase
        end

        // bus match: status, break or trace trigger (set beats clear)
        if (bus_match) begin
            next_state.bus_hit = 1'b1;
            if (state.bus_ctl[`CTL_BREAK] && !in_debug) begin
                next_state.break_pend = 1'b1;
            end
            if (state.bus_ctl[`CTL_TRACE]) begin
                next_state.pcst = retire_i.stalled
                    ? `PCST_STALL_TRIG : `PCST_SEQ_TRIG;
            end
        end

        // probe request held until taken or debug mode masks it
        if (probe_break_i && !in_debug) begin
            next_state.probe_pend = 1'b1;
        end

        // interrupt arriving in debug mode is held for later
        if (nmi_i && (in_debug || any_cause)) begin
            next_state.nmi_pend = 1'b1;
        end
        if (!in_debug && !any_cause && (nmi_i || state.nmi_pend)) begin
            next_state.nmi_take = 1'b1;
            next_state.nmi_pend = 1'b0;
        end

        // debug mode faults: access dropped, no trap
        if (in_debug && translation_fault_i) begin
            next_state.dbg_status[`DBG_TLF] = 1'b1;
            next_state.drop_access = 1'b1;
        end
        if (in_debug && bus_error_i) begin
            next_state.dbg_status[`DBG_BSF] = 1'b1;
            next_state.drop_access = 1'b1;
        end

        // ordinary exceptions yield to debug and to debug mode
        if (exception_i && !in_debug && !any_cause) begin
            next_state.exc_take = 1'b1;
        end

        // indirect jumps emit their target; returns are not traced
        if (retire_i.valid && retire_i.is_indirect) begin
            next_state.trace_valid  = 1'b1;
            next_state.trace_target = retire_i.jump_target;
        end

        // return-target step suppression, extended over a branch slot
        if (retire_i.valid && state.skip_step != 2'h0 && !in_debug) begin
            next_state.skip_step = retire_i.is_branch
                ? 2'h1 : state.skip_step - 2'h1;
        end

        // debug exception entry
        if (any_cause) begin
            next_state.debug_entry = 1'b1;
            next_state.redirect    = 1'b1;
            next_state.redirect_pc = probe_present_i
                ? `VEC_PROBE : `VEC_NO_PROBE;
            next_state.break_status = 1'b1;
            next_state.dbg_status[`DBG_MODE] = 1'b1;
            next_state.dbg_status[`DBG_STEP_CAUSE]  = step_hit;
            next_state.dbg_status[`DBG_BP_CAUSE]    = bp_hit;
            next_state.dbg_status[`DBG_LOAD_CAUSE]  = load_hit;
            next_state.dbg_status[`DBG_IADDR_CAUSE] = iaddr_hit;
            next_state.dbg_status[`DBG_BUS_CAUSE]   = bus_hit;
            next_state.dbg_status[`DBG_PROBE_CAUSE] = probe_hit;
            next_state.dbg_status[`DBG_DELAY_SLOT]  = 1'b0;
            next_state.break_pend = 1'b0;
            next_state.probe_pend = 1'b0;
            // return address by highest-priority cause
            if (iaddr_hit) begin
                next_state.ret_addr = retire_i.pc;
            end else if (bp_hit) begin
                if (retire_i.in_delay_slot) begin
                    next_state.ret_addr = retire_i.branch_pc;
                    next_state.dbg_status[`DBG_DELAY_SLOT] = 1'b1;
                end else begin
                    next_state.ret_addr = retire_i.pc;
                end
            end else if (load_hit || bus_hit) begin
                next_state.ret_addr = retire_i.pc;
            end else if (step_hit) begin
                next_state.ret_addr = retire_i.next_pc;
            end else begin
                next_state.ret_addr = retire_i.pc;
            end
        end

        // debug return
        if (in_debug && retire_i.valid && retire_i.is_return) begin
            next_state.redirect    = 1'b1;
            next_state.redirect_pc = state.ret_addr;
            next_state.dbg_status[`DBG_MODE] = 1'b0;
            next_state.break_status = 1'b0;
            next_state.skip_step    = 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign pready_o         = access;
    assign prdata_o         = state.prdata;
    assign pslverr_o        = state.pslverr;
    assign debug_mode_o     = in_debug;
    assign debug_entry_o    = state.debug_entry;
    assign redirect_o       = state.redirect;
    assign redirect_pc_o    = state.redirect_pc;
    assign nmi_take_o       = state.nmi_take;
    assign exception_take_o = state.exc_take;
    assign irq_mask_o       = in_debug;
    assign drop_access_o    = state.drop_access;
    assign kernel_priv_o    = in_debug || !user_mode_i;
    assign break_status_o   = state.break_status;
    assign pcst_o           = state.pcst;
    assign trace_valid_o    = state.trace_valid;
    assign trace_target_o   = state.trace_target;

endmodule : debug_exception_bus_break

`default_nettype wire

// ==== sim/debug_break_properties.sv ====
// Purpose: port level assertions for the debug exception unit
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound below
`include "debug_break_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module debug_break_properties (
    input wire logic                      sys_clk_i,
    input wire logic                      reset_n_i,
    input wire debug_break_pkg::cpu_bus_t cpu_bus_i,
    input wire debug_break_pkg::retire_t  retire_i,
    input wire logic                      probe_present_i,
    input wire logic                      nmi_i,
    input wire logic                      translation_fault_i,
    input wire logic                      bus_error_i,
    input wire logic                      debug_mode_o,
    input wire logic                      debug_entry_o,
    input wire logic                      redirect_o,
    input wire logic [31:0]               redirect_pc_o,
    input wire logic                      nmi_take_o,
    input wire logic                      exception_take_o,
    input wire logic                      irq_mask_o,
    input wire logic                      drop_access_o,
    input wire logic                      kernel_priv_o,
    input wire logic                      break_status_o,
    input wire logic [2:0]                pcst_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_vector_probe:
    assert property (retire_i.valid && retire_i.is_breakpoint && !debug_mode_o
        && probe_present_i |=> redirect_o && redirect_pc_o == `VEC_PROBE)
        else $error("probe vector wrong");
    a_vector_plain:
    assert property (retire_i.valid && retire_i.is_breakpoint && !debug_mode_o
        && !probe_present_i |=> redirect_o && redirect_pc_o == `VEC_NO_PROBE)
        else $error("default vector wrong");
    a_no_reentry:
    assert property (debug_mode_o && !(retire_i.valid && retire_i.is_return)
        |=> !debug_entry_o) else $error("entry while in debug mode");
    a_entry_mode:
    assert property (debug_entry_o |-> debug_mode_o && redirect_o)
        else $error("entry without mode or redirect");
    a_debug_masks:
    assert property (debug_mode_o |-> irq_mask_o && !nmi_take_o
        && !exception_take_o) else $error("exception taken in debug mode");
    a_kernel_priv:
    assert property (debug_mode_o |-> kernel_priv_o)
        else $error("debug mode lacks kernel privilege");
    a_nmi_held:
    assert property (debug_mode_o && nmi_i ##1 !debug_mode_o |-> ##[0:1]
        nmi_take_o) else $error("held interrupt not taken");
    a_fault_dropped:
    assert property (debug_mode_o && (translation_fault_i || bus_error_i)
        |=> drop_access_o && !exception_take_o) else $error("fault not dropped");
    a_return_exit:
    assert property (debug_mode_o && retire_i.valid && retire_i.is_return
        |=> !debug_mode_o && !break_status_o && redirect_o)
        else $error("return did not leave debug mode");
    a_trace_code:
    assert property (pcst_o != 3'h0 |-> (pcst_o == `PCST_STALL_TRIG
        || pcst_o == `PCST_SEQ_TRIG) && $past(cpu_bus_i.valid))
        else $error("trace code without bus cycle");
endmodule : debug_break_properties
bind debug_exception_bus_break debug_break_properties
    i_debug_break_properties (.*);
`default_nettype wire

// ==== sim/cpu_model.sv ====
// Purpose: pipeline and processor bus side of the debug unit
// Assumes: one bus cycle or retire per call
// Notes:   released address, data and retire fields show inverted values, bus kind goes to CLASS_NONE, never the last ones
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic                sys_clk_i,
    output var debug_break_pkg::cpu_bus_t cpu_bus_o,
    output var debug_break_pkg::retire_t  retire_o
);
    initial begin
        cpu_bus_o = '0;
        retire_o = '0;
    end
    task automatic bus_cycle(input debug_break_pkg::access_class_t k,
                             input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        cpu_bus_o <= '{1'b1, k, a, d};
        @(posedge sys_clk_i);
        cpu_bus_o <= '{1'b0, debug_break_pkg::CLASS_NONE, ~a, ~d};
    endtask : bus_cycle
    task automatic retire(input debug_break_pkg::retire_t r);
        debug_break_pkg::retire_t t;
        t = ~r;
        t.valid = 1'b0;
        @(posedge sys_clk_i);
        retire_o <= r;
        @(posedge sys_clk_i);
        retire_o <= t;
    endtask : retire
endmodule : cpu_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: directed tests of the debug unit
// Assumes: registered outputs one cycle after the cause
// Notes:   cpu side from model
`include "debug_break_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk_i = 1'b0, reset_n_i = 1'b0, seen, err;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata, redirect_pc_o, trace_target_o;
    logic        probe_present_i = 1'b0, probe_break_i = 1'b0, nmi_i = 1'b0;
    logic        irq_i = 1'b0, exception_i = 1'b0, user_mode_i = 1'b0;
    logic        translation_fault_i = 1'b0, bus_error_i = 1'b0;
    logic        pready_o, pslverr_o, debug_mode_o, debug_entry_o, redirect_o;
    logic        nmi_take_o, exception_take_o, irq_mask_o, drop_access_o;
    logic        kernel_priv_o, break_status_o, trace_valid_o;
    logic [2:0]  pcst_o;
    int          tests_run = 0;
    int          miscompares = 0;
    debug_break_pkg::cpu_bus_t cpu_bus_i;
    debug_break_pkg::retire_t  retire_i;
    debug_break_pkg::retire_t  rs = '{valid: 1'b1, stalled: 1'b1, default: '0};
    debug_break_pkg::access_class_t cls [4] = '{
        debug_break_pkg::CLASS_FETCH_UC, debug_break_pkg::CLASS_LOAD_UC,
        debug_break_pkg::CLASS_STORE_UC, debug_break_pkg::CLASS_LOAD_C};
    debug_exception_bus_break i_debug_exception_bus_break (.*);
    cpu_model i_cpu_model (.sys_clk_i(sys_clk_i), .cpu_bus_o(cpu_bus_i),
        .retire_o(retire_i));
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1) @(posedge sys_clk_i);
        rdata = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, exp);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, exp);
    endtask : rd
    task automatic retire_one(input logic [31:0] pc, input logic bp, ds, rt);
        i_cpu_model.retire('{1'b1, pc, pc + 32'h4, pc - 32'h4, ds, 1'b0, bp,
            rt, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0});
        #1;
    endtask : retire_one
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd(8'h18, 32'hFFFF_FFFF, 32'h0);
        rd(8'h40, 32'hFFFF_FFFF, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test registers done");
        wr(8'h04, 32'h0000_1000);
        wr(8'h08, 32'hCAFE_0000);
        wr(8'h0C, 32'h0000_FFFF);
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, 32'h10 | (32'h1 << i));
            i_cpu_model.bus_cycle(cls[i], 32'h1000, 32'hCAFE_1234);
            #1 chk({29'h0, pcst_o}, 32'h1);
            i_cpu_model.bus_cycle(cls[(i + 1) % 4], 32'h1000, 32'hCAFE_1234);
            #1 chk({29'h0, pcst_o}, 32'h0);
        end
        i_cpu_model.bus_cycle(cls[3], 32'h1000, 32'hCAFF_1234);
        #1 chk({29'h0, pcst_o}, 32'h0);
        i_cpu_model.bus_cycle(cls[3], 32'h1004, 32'hCAFE_1234);
        #1 chk({29'h0, pcst_o}, 32'h0);
        fork
            i_cpu_model.bus_cycle(cls[3], 32'h1000, 32'hCAFE_0000);
            i_cpu_model.retire(rs);
        join
        #1 chk({29'h0, pcst_o}, 32'h2);
        retire_one(32'h1500, 1'b0, 1'b0, 1'b0);
        chk({31'h0, debug_mode_o}, 32'h0);
        rd(8'h00, 32'h1, 32'h1);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h1, 32'h0);
        $display("test trace done");
        probe_present_i <= 1'b1;
        wr(8'h10, 32'h22);
        i_cpu_model.bus_cycle(cls[1], 32'h1000, 32'hCAFE_0000);
        retire_one(32'h2000, 1'b0, 1'b0, 1'b0);
        chk(redirect_pc_o, `VEC_PROBE);
        chk({31'h0, debug_mode_o}, 32'h1);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h2000);
        rd(8'h18, 32'h4000_0020, 32'h4000_0020);
        $display("test bus break done");
        user_mode_i <= 1'b1;
        irq_i <= 1'b1;
        nmi_i <= 1'b1;
        exception_i <= 1'b1;
        translation_fault_i <= 1'b1;
        @(posedge sys_clk_i);
        nmi_i <= 1'b0;
        exception_i <= 1'b0;
        translation_fault_i <= 1'b0;
        bus_error_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_error_i <= 1'b0;
        #1 chk({31'h0, kernel_priv_o}, 32'h1);
        chk({31'h0, irq_mask_o}, 32'h1);
        retire_one(32'h2100, 1'b1, 1'b0, 1'b0);
        chk({31'h0, debug_entry_o}, 32'h0);
        rd(8'h18, 32'h0000_1800, 32'h0000_1800);
        retire_one(32'h2104, 1'b0, 1'b0, 1'b1);
        chk(redirect_pc_o, 32'h2000);
        chk({31'h0, debug_mode_o}, 32'h0);
        seen = 1'b0;
        repeat (3) begin
            @(posedge sys_clk_i);
            #1 seen = seen | nmi_take_o;
        end
        chk({31'h0, seen}, 32'h1);
        $display("test debug mode done");
        probe_present_i <= 1'b0;
        retire_one(32'h3004, 1'b1, 1'b1, 1'b0);
        chk(redirect_pc_o, `VEC_NO_PROBE);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h3000);
        rd(8'h18, 32'h8000_0002, 32'h8000_0002);
        retire_one(32'h3008, 1'b0, 1'b0, 1'b1);
        $display("test breakpoint done");
        probe_present_i <= 1'b1;
        probe_break_i <= 1'b1;
        @(posedge sys_clk_i);
        probe_break_i <= 1'b0;
        retire_one(32'h4000, 1'b0, 1'b0, 1'b0);
        chk(redirect_pc_o, `VEC_PROBE);
        rd(8'h1C, 32'hFFFF_FFFF, 32'h4000);
        rd(8'h18, 32'h0000_0040, 32'h0000_0040);
        retire_one(32'h4004, 1'b0, 1'b0, 1'b1);
        $display("test probe break done");
        i_cpu_model.retire('{valid: 1'b1, is_indirect: 1'b1,
            jump_target: 32'h5000, default: '0});
        #1 chk({trace_valid_o, trace_target_o[30:0]}, 32'h8000_5000);
        final_report();
    end
endmodule : testbench
`default_nettype wire
